// File: bench/sdct_chk_assertions.sv
/* Port checker for sdct_core. Assumes a bind to every core instance. */
module sdct_chk (
  input wire MCLK_IN, input wire RESET_IN, input wire [2:0] CMD_IN, input wire CKE_IN,
  input wire CL3_IN, input wire DQM_IN, input wire DQ_OE_N_OUT, input wire WR_EN_OUT,
  input wire CLK_ACTIVE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  wire w = CMD_IN == 3'h2 && CLK_ACTIVE_OUT;
  wire q = CMD_IN == 3'h0 && !DQM_IN && CKE_IN;
  AST_B2B: assert property (w ##1 (w && !DQM_IN) |=> WR_EN_OUT) else $error("lost");
  AST_MASK: assert property (w && DQM_IN |=> !WR_EN_OUT) else $error("mask");
  AST_OFF: assert property (!CKE_IN |=> !CLK_ACTIVE_OUT) else $error("off");
  AST_ON: assert property (CKE_IN |=> CLK_ACTIVE_OUT) else $error("on");
  AST_DQM: assert property (DQM_IN && CLK_ACTIVE_OUT && CKE_IN ##1 CKE_IN [*2]
    |=> DQ_OE_N_OUT) else $error("dqm");
  AST_PRE: assert property (CMD_IN == 3'h3 && CLK_ACTIVE_OUT && CKE_IN && !CL3_IN ##1 q [*2]
    |=> DQ_OE_N_OUT) else $error("pre");
endmodule

// File: bench/sdct_core_tb_top.sv
/* Bench for sdct_core. Assumes the controller model and the checker. */
module sdct_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, cl3 = 0;
  wire [2:0] cmd;
  wire cke, dqm, oe, we, act;
  wire [15:0] dq, wd, rd;
  int bad_count = 0, checks = 0;
  always #50 clk = ~clk;
  sdct_ctrl_model ctl(.clk_in(clk), .cmd_out(cmd), .cke_out(cke), .dqm_out(dqm), .dq_out(dq));
  sdct_core i_dut(.MCLK_IN(clk), .RESET_IN(rst), .CMD_IN(cmd), .CKE_IN(cke), .CL3_IN(cl3),
    .BURST_LEN_IN(4'h4), .DQM_IN(dqm), .DQ_IN(dq), .RD_DATA_IN(16'hA5A5), .DQ_OUT(rd),
    .DQ_OE_N_OUT(oe), .WR_EN_OUT(we), .WR_DATA_OUT(wd), .CLK_ACTIVE_OUT(act));
  task chk(input logic ok);
    checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("wrong value at %0t, check %0d", $time, checks);
    end
  endtask
  task end_sim;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task t_write;
    ctl.issue(3'h2, 16'h1234, 0);
    ctl.issue(3'h2, 16'h5678, 0);
    chk(we === 1'b1 && wd === 16'h1234);
    ctl.issue(3'h2, 16'h9ABC, 1);
    chk(we === 1'b1 && wd === 16'h5678);
    ctl.issue(3'h0, 16'h0, 0);
    chk(we === 1'b0);
  endtask
  task t_read(input logic c3, input logic [2:0] c, input logic m);
    cl3 = c3;
    ctl.issue(3'h1, 16'h0, 0);
    ctl.issue(c, 16'h0, m);
    ctl.issue(3'h0, 16'h0, 0);
    repeat (c3 ? 2 : 1) @(negedge clk);
    chk(oe === 1'b0 && rd === 16'hA5A5);
    @(negedge clk);
    chk(oe === (c != 3'h0 || m));
    repeat (4) @(negedge clk);
  endtask
  task t_cke;
    ctl.cke_out = 0;
    ctl.issue(3'h2, 16'h0, 0);
    chk(act === 1'b0);
    ctl.cke_out = 1;
    ctl.issue(3'h0, 16'h0, 0);
    chk(we === 1'b0 && act === 1'b1);
    ctl.issue(3'h2, 16'h0055, 0);
    ctl.issue(3'h0, 16'h0, 0);
    chk(we === 1'b1 && wd === 16'h0055);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_write;
    t_read(0, 3'h0, 0);
    t_read(1, 3'h0, 0);
    t_read(0, 3'h3, 0);
    t_read(1, 3'h3, 0);
    t_read(0, 3'h0, 1);
    t_cke;
    end_sim;
  end
  initial
  begin
    #100000;
    bad_count++;
    end_sim;
  end
endmodule
bind sdct_core sdct_chk i_chk(.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .CMD_IN(CMD_IN),
  .CKE_IN(CKE_IN), .CL3_IN(CL3_IN), .DQM_IN(DQM_IN), .DQ_OE_N_OUT(DQ_OE_N_OUT),
  .WR_EN_OUT(WR_EN_OUT), .CLK_ACTIVE_OUT(CLK_ACTIVE_OUT));

// File: bench/sdct_ctrl_model.sv
/* Controller model. Assumes the bench calls issue and sets cke_out. */
module sdct_ctrl_model (input wire clk_in, output logic [2:0] cmd_out, output logic cke_out,
  output logic dqm_out, output logic [15:0] dq_out);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cmd_out, cke_out, dqm_out, dq_out} = 21'h20000;
  // Sends column, nop and precharge only; no row, refresh or mode command,
  // so those spacings hold trivially
  // One 100 ns cycle covers every ns minimum
  task automatic issue(input logic [2:0] c, input logic [15:0] d, input logic m);
    @(negedge clk_in);
    cmd_out = c;
    dq_out = d;
    dqm_out = m;
  endtask
endmodule

// File: core/sdct_core.v
/*
  Device-side data path timing of a four-bank SDRAM: clock enable gating,
  data mask on writes and reads, read latency and output float control.
  Assumes the controller honours all command spacings; commands arrive decoded
  and synchronous to MCLK_IN.
*/
`include "sdct_consts.vh"

// Overview of operation
// - Read or write commands may arrive every cycle; each restarts the burst.
// - Clock enable sampled low suspends internal clocking one cycle later.
// - Clock enable high resumes clocking one cycle later.
// - Write word under asserted mask in the same cycle is not written.
// - Read outputs float two cycles after mask is asserted.
// - Precharge during read floats outputs after read latency cycles.
module sdct_core #(
  parameter DATA_W = 16
) (
  // Clock and reset
  input wire MCLK_IN,
  input wire RESET_IN,
  // Decoded command
  input wire [2:0] CMD_IN,
  input wire CKE_IN,
  input wire CL3_IN,
  input wire [`SDCT_BURST_W-1:0] BURST_LEN_IN,
  // Data path
  input wire DQM_IN,
  input wire [DATA_W-1:0] DQ_IN,
  input wire [DATA_W-1:0] RD_DATA_IN,
  output reg [DATA_W-1:0] DQ_OUT,
  output reg DQ_OE_N_OUT,
  // Array write port
  output reg WR_EN_OUT,
  output reg [DATA_W-1:0] WR_DATA_OUT,
  // Status
  output reg CLK_ACTIVE_OUT
);

  // Burst counters and latency pipelines
  reg [`SDCT_BURST_W-1:0] wr_left;
  reg [`SDCT_BURST_W-1:0] rd_left;
  reg [2:0] rd_pipe;
  reg [1:0] dqm_pipe;
  reg [2:0] float_pipe;

  // Next values
  reg [`SDCT_BURST_W-1:0] next_wr_left;
  reg next_wr_en;
  reg [DATA_W-1:0] next_wr_data;
  reg [`SDCT_BURST_W-1:0] next_rd_left;
  reg [2:0] next_rd_pipe;
  reg next_oe_n;

  // Decoded strobes
  wire run;
  wire is_nop;
  wire is_wr;
  wire is_rd;
  wire is_stop;
  wire is_pre;
  wire rd_cmd_now;
  wire rd_now;
  wire float_now;

  // True when the decoded command carries the wanted code
  function cmd_is;
    input [2:0] cmd;
    input [2:0] code;
    begin
      cmd_is = (cmd == code);
    end
  endfunction

  // Words still to come after the first word of a burst
  function [`SDCT_BURST_W-1:0] burst_rest;
    input [`SDCT_BURST_W-1:0] len;
    begin
      if (len == {`SDCT_BURST_W{1'b0}})
        burst_rest = {`SDCT_BURST_W{1'b0}};
      else
        burst_rest = len - {{(`SDCT_BURST_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // One burst word done, holding at zero
  function [`SDCT_BURST_W-1:0] count_down;
    input [`SDCT_BURST_W-1:0] left;
    begin
      if (left == {`SDCT_BURST_W{1'b0}})
        count_down = left;
      else
        count_down = left - {{(`SDCT_BURST_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Pipeline stage that matches the selected read latency
  function latency_tap;
    input [2:0] pipe;
    input cl3;
    begin
      if (cl3)
        latency_tap = pipe[2];
      else
        latency_tap = pipe[1];
    end
  endfunction

  // Internal clock runs when enable was high one cycle earlier
  assign run = CLK_ACTIVE_OUT;
  assign is_nop = run && cmd_is(CMD_IN, `SDCT_CMD_NOP);
  assign is_wr = run && cmd_is(CMD_IN, `SDCT_CMD_WRITE);
  assign is_rd = run && cmd_is(CMD_IN, `SDCT_CMD_READ);
  assign is_stop = run && cmd_is(CMD_IN, `SDCT_CMD_STOP);
  assign is_pre = run && cmd_is(CMD_IN, `SDCT_CMD_PRECHARGE);
  assign rd_cmd_now = is_rd || (run && rd_left != {`SDCT_BURST_W{1'b0}});
  // Data appears after latency 2 or 3
  assign rd_now = latency_tap(rd_pipe, CL3_IN);
  // Precharge float after 3 or 2 cycles
  assign float_now = latency_tap(float_pipe, CL3_IN);

  always @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      CLK_ACTIVE_OUT <= 1'b1;
    else
      CLK_ACTIVE_OUT <= CKE_IN;
  end

  // Write path: first word with the command, mask has no latency
  always @*
  begin
    next_wr_left = wr_left;
    next_wr_en = 1'b0;
    next_wr_data = WR_DATA_OUT;
    if (is_rd || is_stop || is_pre)
      next_wr_left = {`SDCT_BURST_W{1'b0}};
    if (is_wr)
    begin
      next_wr_left = burst_rest(BURST_LEN_IN);
      next_wr_en = ~DQM_IN;
      next_wr_data = DQ_IN;
    end
    else if (is_nop && wr_left != {`SDCT_BURST_W{1'b0}})
    begin
      next_wr_left = count_down(wr_left);
      next_wr_en = ~DQM_IN;
      next_wr_data = DQ_IN;
    end
  end

  always @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      wr_left <= {`SDCT_BURST_W{1'b0}};
      WR_EN_OUT <= 1'b0;
      WR_DATA_OUT <= {DATA_W{1'b0}};
    end
    else
    begin
      wr_left <= next_wr_left;
      WR_EN_OUT <= next_wr_en;
      WR_DATA_OUT <= next_wr_data;
    end
  end

  // Read path: a write drops pending read data at once
  always @*
  begin
    next_rd_left = rd_left;
    next_rd_pipe = rd_pipe;
    next_oe_n = DQ_OE_N_OUT;
    if (run)
    begin
      if (is_rd)
        next_rd_left = burst_rest(BURST_LEN_IN);
      else if (is_wr || is_stop || is_pre)
        next_rd_left = {`SDCT_BURST_W{1'b0}};
      else
        next_rd_left = count_down(rd_left);
      next_rd_pipe = {rd_pipe[1:0], rd_cmd_now && !is_wr};
      if (float_now || is_wr)
      begin
        next_oe_n = 1'b1;
        next_rd_pipe = 3'h0;
      end
      else
        next_oe_n = ~(rd_now && !dqm_pipe[1]);
    end
  end

  // Pipelines freeze while the internal clock is stopped
  always @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      rd_left <= {`SDCT_BURST_W{1'b0}};
      rd_pipe <= 3'h0;
      dqm_pipe <= 2'h0;
      float_pipe <= 3'h0;
      DQ_OUT <= {DATA_W{1'b0}};
      DQ_OE_N_OUT <= 1'b1;
    end
    else
    begin
      rd_left <= next_rd_left;
      rd_pipe <= next_rd_pipe;
      DQ_OE_N_OUT <= next_oe_n;
      if (run)
      begin
        dqm_pipe <= {dqm_pipe[0], DQM_IN};
        float_pipe <= {float_pipe[1:0], is_pre};
        DQ_OUT <= RD_DATA_IN;
      end
    end
  end

endmodule

// File: inc/sdct_consts.vh
/*
  Timing constants for the SDRAM command timing core.
  Assumes a 10 MHz clock (100 ns period); figures are given in whole cycles.
*/
`ifndef SDCT_CONSTS_VH
`define SDCT_CONSTS_VH
`define SDCT_CLK_PERIOD_NS 100
`define SDCT_CCD_CYC 1
`define SDCT_CKE_ENTRY_CYC 1
`define SDCT_CKE_EXIT_CYC 1
`define SDCT_DQM_WR_CYC 0
`define SDCT_DQM_RD_CYC 2
`define SDCT_FLOAT_CL3_CYC 3
`define SDCT_FLOAT_CL2_CYC 2
`define SDCT_CMD_NOP 3'h0
`define SDCT_CMD_READ 3'h1
`define SDCT_CMD_WRITE 3'h2
`define SDCT_CMD_PRECHARGE 3'h3
`define SDCT_CMD_STOP 3'h4
`define SDCT_CMD_OTHER 3'h7
`define SDCT_BURST_W 4
`define SDCT_BURST_DEF 4'h4
`endif
